// ==== core/trig_cap_pkg.sv ====
// Constants, register map and types for the trigger and capture block
package trig_cap_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_CH = 16;
  localparam int SMP_W = 8;
  localparam int REC_LEN = 64;
  localparam int REC_AW = 6;
  localparam int TMR_W = 24;
  localparam logic [6:0] PCT_MAX = 7'h64;

  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_SRC = 4'h1;
  localparam logic [3:0] OFS_LEVEL = 4'h2;
  localparam logic [3:0] OFS_PRETRIG = 4'h3;
  localparam logic [3:0] OFS_HOLDOFF = 4'h4;
  localparam logic [3:0] OFS_AUTO_TO = 4'h5;
  localparam logic [3:0] OFS_STATUS = 4'h6;
  localparam logic [3:0] OFS_TZERO = 4'h7;

  // Control register fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_AUTO_BIT = 1;
  localparam int CTRL_FALL_BIT = 2;
  localparam int CTRL_TYPE_LSB = 3;
  localparam int CTRL_FORCE_BIT = 8;

  // Source codes above the channel range
  localparam logic [4:0] SRC_LINE = 5'h10;
  localparam logic [4:0] SRC_AUX = 5'h11;

  // Reset values
  localparam logic [4:0] SRC_RST = 5'h00;
  localparam logic [7:0] LEVEL_RST = 8'h80;
  localparam logic [6:0] PRETRIG_RST = 7'h32;
  localparam logic [TMR_W-1:0] HOLDOFF_RST = 24'h000010;
  localparam logic [TMR_W-1:0] AUTO_TO_RST = 24'h001000;

  // Line source: 60 Hz from a 200 MHz clock
  localparam int CLK_HZ = 200_000_000;
  localparam int LINE_HZ = 60;
  localparam int LINE_HALF_CYC = CLK_HZ / LINE_HZ / 2;

  typedef enum logic [2:0] {
    TYP_EDGE, TYP_PULSE, TYP_PATTERN, TYP_STATE, TYP_SEQUENCE
  } trig_type_e;

  typedef struct packed {
    logic signed [7:0] rel_t;
    logic [SMP_W-1:0] smp;
  } rec_word_s;

endpackage

// ==== core/trig_cap.sv ====
// Edge trigger, pretrigger history and record capture with readout
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ps

// What this block does
// [RULE1] Trigger sample is time zero of record
// [RULE2] Keep sampling and hold pretrigger history while waiting
// [RULE3] After trigger, store posttrigger samples
// [RULE4] Ignore triggers until record is complete; a software force written during the record is held and taken once armed again
// [RULE5] Edge trigger on threshold crossing, chosen slope
// [RULE6] Any of sixteen channels selectable as source
// [RULE7] Source works independent of display or group
// [RULE8] Line source generated internally
// [RULE9] Auxiliary source comes from external input
// [RULE10] Type selector offers pulse, pattern, state, sequence; the type is only stored, and only the edge type fires on a threshold crossing
// [RULE11] Holdoff keeps trigger disabled after acquisition
// [RULE12] Auto mode forces trigger on timeout; normal never
// [RULE13] Pretrigger percentage sets record split
// [RULE14] Circular buffer overwrites oldest until trigger
module trig_cap
  import trig_cap_pkg::*;
#(
  parameter int LINE_CYC = LINE_HALF_CYC
) (
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic [NUM_CH-1:0][SMP_W-1:0] CH_I,
  input wire logic SMP_VLD_I,
  input wire logic AUX_I,
  input wire logic [3:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  output logic TRIG_O,
  output logic BUSY_O,
  output logic REC_VLD_O,
  input wire logic REC_RDY_I,
  output rec_word_s REC_DAT_O
);

  // ----------------------------------------------------------------
  // Types and helpers
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_FILL, ST_ARMED, ST_POST, ST_DUMP, ST_HOLD
  } state_e;

  function automatic logic [REC_AW:0] pct_to_len(input logic [6:0] pct);
    logic [13:0] prod;
    prod = 14'(pct) * 14'(REC_LEN);
    return (REC_AW+1)'(prod / 14'(PCT_MAX));
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic en_r;
  logic auto_r;
  logic fall_r;
  trig_type_e type_r;
  logic [4:0] src_r;
  logic [7:0] level_r;
  logic [6:0] pct_r;
  logic [TMR_W-1:0] holdoff_r;
  logic [TMR_W-1:0] auto_to_r;
  logic force_r;
  logic forced_last_r;
  logic [REC_AW-1:0] tzero_r;
  logic [31:0] rdata_r;

  state_e state_r;
  state_e state_nxt;
  logic [SMP_W-1:0] mem_r [REC_LEN];
  logic [REC_AW-1:0] wptr_r;
  logic [REC_AW:0] cnt_r;
  logic [TMR_W-1:0] tmr_r;
  logic above_r;
  logic prev_ok_r;
  logic [31:0] line_cnt_r;
  logic line_lvl_r;
  logic trig_r;

  rec_word_s ent_r [2];
  logic [1:0] fill_r;

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  wire ctrl_wr = WR_I && (ADDR_I == OFS_CTRL);
  wire force_req = ctrl_wr && WDATA_I[CTRL_FORCE_BIT];
  wire [6:0] pct_clip = (WDATA_I[6:0] > PCT_MAX) ? PCT_MAX : WDATA_I[6:0];
  wire [REC_AW:0] pre_raw = pct_to_len(pct_r);
  // At least the trigger sample stays in the post section
  wire [REC_AW:0] pre_len = (pre_raw > (REC_AW+1)'(REC_LEN - 1)) ?
                            (REC_AW+1)'(REC_LEN - 1) : pre_raw; // RULE13
  wire [REC_AW:0] post_len = (REC_AW+1)'(REC_LEN) - pre_len; // RULE13

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      en_r <= 1'b0;
      auto_r <= 1'b0;
      fall_r <= 1'b0;
      type_r <= TYP_EDGE;
      src_r <= SRC_RST;
      level_r <= LEVEL_RST;
      pct_r <= PRETRIG_RST;
      holdoff_r <= HOLDOFF_RST;
      auto_to_r <= AUTO_TO_RST;
    end else if (WR_I) begin
      case (ADDR_I)
        OFS_CTRL: begin
          en_r <= WDATA_I[CTRL_EN_BIT];
          auto_r <= WDATA_I[CTRL_AUTO_BIT];
          fall_r <= WDATA_I[CTRL_FALL_BIT];
          type_r <= trig_type_e'(WDATA_I[CTRL_TYPE_LSB +: 3]); // RULE10
        end
        OFS_SRC: src_r <= WDATA_I[4:0];
        OFS_LEVEL: level_r <= WDATA_I[7:0];
        OFS_PRETRIG: pct_r <= pct_clip;
        OFS_HOLDOFF: holdoff_r <= WDATA_I[TMR_W-1:0];
        OFS_AUTO_TO: auto_to_r <= WDATA_I[TMR_W-1:0];
        default: ;
      endcase
    end
  end

  // Software force is held until the armed state can take it
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      force_r <= 1'b0;
    end else if (force_req) begin
      force_r <= 1'b1;
    end else if ((state_r == ST_ARMED && SMP_VLD_I) || !en_r) begin
      force_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read port, data one cycle after the strobe
  // ----------------------------------------------------------------
  wire [31:0] rd_mux =
    (ADDR_I == OFS_CTRL) ?
      {26'h0, type_r, fall_r, auto_r, en_r} :
    (ADDR_I == OFS_SRC) ? {27'h0, src_r} :
    (ADDR_I == OFS_LEVEL) ? {24'h0, level_r} :
    (ADDR_I == OFS_PRETRIG) ? {25'h0, pct_r} :
    (ADDR_I == OFS_HOLDOFF) ? {8'h0, holdoff_r} :
    (ADDR_I == OFS_AUTO_TO) ? {8'h0, auto_to_r} :
    (ADDR_I == OFS_STATUS) ? {27'h0, forced_last_r, 1'b0, state_r} :
    (ADDR_I == OFS_TZERO) ? {26'h0, tzero_r} :
    32'h0000_0000;

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      rdata_r <= 32'h0000_0000;
    end else if (RD_I) begin
      rdata_r <= rd_mux;
    end else begin
      rdata_r <= 32'h0000_0000;
    end
  end

  assign RDATA_O = rdata_r;

  // ----------------------------------------------------------------
  // Source selection
  // ----------------------------------------------------------------
  // Internal line-frequency square wave, no input needed
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      line_cnt_r <= 32'h0000_0000;
      line_lvl_r <= 1'b0;
    end else if (line_cnt_r >= 32'(LINE_CYC - 1)) begin
      line_cnt_r <= 32'h0000_0000;
      line_lvl_r <= ~line_lvl_r; // RULE8
    end else begin
      line_cnt_r <= line_cnt_r + 32'h0000_0001;
    end
  end

  // Channel path ignores display and group state entirely
  wire [SMP_W-1:0] ch_smp = CH_I[src_r[3:0]]; // RULE6 RULE7
  wire [SMP_W-1:0] line_smp = line_lvl_r ? 8'hFF : 8'h00; // RULE8
  wire [SMP_W-1:0] aux_smp = AUX_I ? 8'hFF : 8'h00; // RULE9
  wire [SMP_W-1:0] src_smp =
    (src_r == SRC_LINE) ? line_smp :
    (src_r == SRC_AUX) ? aux_smp :
    (src_r[4] == 1'b0) ? ch_smp : 8'h00;

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  wire above = src_smp >= level_r;
  wire rise = prev_ok_r && !above_r && above;
  wire fall = prev_ok_r && above_r && !above;
  wire edge_hit = SMP_VLD_I && (type_r == TYP_EDGE) &&
                  (fall_r ? fall : rise); // RULE5

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      above_r <= 1'b0;
      prev_ok_r <= 1'b0;
    end else if (SMP_VLD_I) begin
      above_r <= above;
      prev_ok_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Trigger acceptance
  // ----------------------------------------------------------------
  wire tmr_exp = auto_r && (tmr_r >= auto_to_r); // RULE12
  wire armed = state_r == ST_ARMED;
  wire take = armed && SMP_VLD_I &&
              (edge_hit || tmr_exp || force_r); // RULE4 RULE12
  wire out_rdy = fill_r != 2'd2;
  wire dump_push = (state_r == ST_DUMP) && out_rdy;
  // Trigger sample counts as the first post sample
  wire last_post = cnt_r + (REC_AW+1)'(1) >= post_len;
  wire store = SMP_VLD_I && (state_r == ST_FILL || armed ||
               (state_r == ST_POST && !last_post));

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (en_r) state_nxt = ST_FILL;
      ST_FILL: if (SMP_VLD_I && cnt_r >= pre_len) state_nxt = ST_ARMED;
      ST_ARMED: if (take) state_nxt = ST_POST; // RULE3
      ST_POST: if (last_post) state_nxt = ST_DUMP;
      ST_DUMP:
        if (dump_push && cnt_r == (REC_AW+1)'(REC_LEN - 1)) begin
          state_nxt = ST_HOLD;
        end
      ST_HOLD: if (tmr_r >= holdoff_r) state_nxt = ST_IDLE; // RULE11
      default: state_nxt = ST_IDLE;
    endcase
    if (!en_r && state_r != ST_DUMP) begin
      state_nxt = ST_IDLE;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Counter of stored, posttrigger or read-out samples
  always_ff @(posedge MCLK_I) begin
    if (RST_I || state_nxt != state_r) begin
      cnt_r <= '0;
    end else if (dump_push || (store && state_r != ST_ARMED &&
                 cnt_r != (REC_AW+1)'(REC_LEN))) begin
      cnt_r <= cnt_r + (REC_AW+1)'(1);
    end
  end

  // Auto timer while armed, holdoff timer after the record
  always_ff @(posedge MCLK_I) begin
    if (RST_I || state_nxt != state_r) begin
      tmr_r <= '0;
    end else if (armed || state_r == ST_HOLD) begin
      tmr_r <= tmr_r + TMR_W'(1); // RULE11 RULE12
    end
  end

  // ----------------------------------------------------------------
  // Record memory
  // ----------------------------------------------------------------
  // Write pointer wraps and overwrites the oldest sample
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      wptr_r <= '0;
    end else if (store) begin
      wptr_r <= wptr_r + REC_AW'(1); // RULE2 RULE14
    end else if (dump_push) begin
      wptr_r <= wptr_r + REC_AW'(1);
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (store) begin
      mem_r[wptr_r] <= src_smp; // RULE2 RULE3 RULE14
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      tzero_r <= '0;
      forced_last_r <= 1'b0;
      trig_r <= 1'b0;
    end else begin
      trig_r <= take;
      if (take) begin
        tzero_r <= wptr_r; // RULE1
        forced_last_r <= !edge_hit;
      end
    end
  end

  assign TRIG_O = trig_r;
  assign BUSY_O = state_r == ST_POST || state_r == ST_DUMP;

  // ----------------------------------------------------------------
  // Readout buffer
  // ----------------------------------------------------------------
  // Oldest first; after the post phase wptr_r points at the oldest
  rec_word_s push_w;
  assign push_w.smp = mem_r[wptr_r];
  assign push_w.rel_t = 8'(cnt_r) - 8'(pre_len); // RULE1

  wire pop = REC_VLD_O && REC_RDY_I;

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      fill_r <= 2'd0;
    end else if (dump_push && !pop) begin
      fill_r <= fill_r + 2'd1;
    end else if (pop && !dump_push) begin
      fill_r <= fill_r - 2'd1;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      ent_r[0] <= '0;
      ent_r[1] <= '0;
    end else begin
      if (pop) begin
        ent_r[0] <= (fill_r == 2'd2) ? ent_r[1] : push_w;
      end else if (dump_push && fill_r == 2'd0) begin
        ent_r[0] <= push_w;
      end
      if (dump_push && ((fill_r == 2'd1 && !pop) ||
                        (fill_r == 2'd2 && pop))) begin
        ent_r[1] <= push_w;
      end
    end
  end

  assign REC_VLD_O = fill_r != 2'd0;
  assign REC_DAT_O = ent_r[0];

endmodule // trig_cap

// ==== bench/samp_src.sv ====
// Behavioural model of the sampled channels and the auxiliary input
`timescale 1ns/1ps
module samp_src
  import trig_cap_pkg::*;
(
  input wire logic clk_i,
  input wire logic slow_i,
  input wire logic [3:0] sel_i,
  input wire logic [7:0] val_i,
  output logic [NUM_CH-1:0][SMP_W-1:0] ch_o,
  output logic vld_o,
  output logic aux_o
);
  logic ph = 1'b0;
  logic nv;
  // Slow mode gives a sample every other cycle
  assign nv = ~slow_i | ph;
  initial begin
    ch_o = '0;
    vld_o = 1'b0;
    aux_o = 1'b0;
  end
  // Data between samples is inverted so stale use shows up
  always @(posedge clk_i) begin
    ph <= ~ph;
    vld_o <= nv;
    for (int i = 0; i < NUM_CH; i++) begin
      ch_o[i] <= (i == sel_i && nv) ? val_i : ~val_i;
    end
    aux_o <= nv ? val_i[7] : ~val_i[7];
  end
endmodule // samp_src

// ==== bench/trig_cap_checker.sv ====
// Assertion checker for the trigger and capture block
`timescale 1ns/1ps
module trig_cap_checker
  import trig_cap_pkg::*;
(
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic SMP_VLD_I,
  input wire logic [3:0] ADDR_I,
  input wire logic RD_I,
  input wire logic [31:0] RDATA_O,
  input wire logic TRIG_O,
  input wire logic BUSY_O,
  input wire logic REC_VLD_O,
  input wire logic REC_RDY_I,
  input wire rec_word_s REC_DAT_O
);
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (RST_I);
  // ------
  // Register bus
  // ------
  property p_rd_idle;
    !$past(RD_I) |-> RDATA_O == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero outside a read");
  property p_rd_unmap;
    RD_I && ADDR_I > 4'h7 |=> RDATA_O == 32'h0;
  endproperty
  a_rd_unmap: assert property (p_rd_unmap)
    else $error("unmapped read not zero");
  property p_pct_max;
    RD_I && ADDR_I == OFS_PRETRIG |=> RDATA_O <= 32'(PCT_MAX);
  endproperty
  a_pct_max: assert property (p_pct_max)
    else $error("percentage above limit");
  // ------
  // Trigger and record
  // ------
  property p_trig_one;
    TRIG_O |=> !TRIG_O;
  endproperty
  a_trig_one: assert property (p_trig_one)
    else $error("trigger pulse longer than one cycle");
  property p_trig_lock;
    TRIG_O |-> BUSY_O && !$past(BUSY_O);
  endproperty
  a_trig_lock: assert property (p_trig_lock)
    else $error("trigger taken during capture");
  property p_trig_vld;
    TRIG_O |-> $past(SMP_VLD_I);
  endproperty
  a_trig_vld: assert property (p_trig_vld)
    else $error("trigger without a sample");
  property p_busy_cause;
    $rose(BUSY_O) |-> TRIG_O;
  endproperty
  a_busy_cause: assert property (p_busy_cause)
    else $error("capture started without trigger");
  property p_rec_hold;
    REC_VLD_O && !REC_RDY_I |=> REC_VLD_O && $stable(REC_DAT_O);
  endproperty
  a_rec_hold: assert property (p_rec_hold)
    else $error("record word dropped while stalled");
  c_trig: cover property (TRIG_O);
  c_stall: cover property (REC_VLD_O && !REC_RDY_I);
  c_unmap: cover property (RD_I && ADDR_I > 4'h7);
endmodule // trig_cap_checker

bind trig_cap trig_cap_checker u_chk (.MCLK_I, .RST_I, .SMP_VLD_I, .ADDR_I,
  .RD_I, .RDATA_O, .TRIG_O, .BUSY_O, .REC_VLD_O, .REC_RDY_I, .REC_DAT_O);

// ==== bench/edge_trigger_capture_control_tb_top.sv ====
// Self-checking bench for the trigger and capture block
`timescale 1ns/1ps
module edge_trigger_capture_control_tb_top;
  import trig_cap_pkg::*;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic rdy = 1'b0, slow = 1'b0;
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] wd = 32'h0, q, rdat;
  logic [7:0] val = 8'h00;
  logic [NUM_CH-1:0][SMP_W-1:0] ch;
  logic vld, aux, trg, bsy, rv;
  rec_word_s rw;
  int errors = 0, checks = 0, ntrig = 0;

  samp_src u_src (.clk_i(clk), .slow_i(slow), .sel_i(sel), .val_i(val),
    .ch_o(ch), .vld_o(vld), .aux_o(aux));
  trig_cap #(.LINE_CYC(8)) u_dut (.MCLK_I(clk), .RST_I(rst), .CH_I(ch),
    .SMP_VLD_I(vld), .AUX_I(aux), .ADDR_I(adr), .WDATA_I(wd), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdat), .TRIG_O(trg), .BUSY_O(bsy),
    .REC_VLD_O(rv), .REC_RDY_I(rdy), .REC_DAT_O(rw));

  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (trg === 1'b1)
      ntrig++;
  end

  task automatic give_verdict;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic bail(string n);
    errors++;
    $display("Error %s expected done seen timeout", n);
    give_verdict;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr_reg(logic [3:0] a, logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    adr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdat;
  endtask
  task automatic wait_st(logic [2:0] s);
    int n;
    n = 0;
    rd_reg(OFS_STATUS, q);
    while (q[2:0] !== s) begin
      n++;
      if (n > 400)
        bail("state");
      rd_reg(OFS_STATUS, q);
    end
  endtask
  task automatic wait_trig(int lim, int t0);
    int n;
    n = 0;
    while (trg !== 1'b1 && ntrig == t0) begin
      @(posedge clk);
      n++;
      if (n > lim)
        bail("trigger");
    end
  endtask
  // Receiver stalls at first and then one cycle in four
  task automatic drain(int pre, logic [7:0] lo, hi, logic full);
    int k, n;
    k = 0;
    n = 0;
    while (k < REC_LEN && n < 2000) begin
      @(posedge clk);
      n++;
      if (rv === 1'b1 && rdy === 1'b1) begin
        chk("rel_t", 32'(k - pre), 32'(rw.rel_t));
        if (full || k == pre - 1 || k == pre)
          chk("smp", k < pre ? lo : hi, 32'(rw.smp));
        k++;
      end
      rdy <= n > 12 && (n[0] | n[1]);
    end
    rdy <= 1'b0;
    if (k < REC_LEN)
      bail("record");
  endtask

  task automatic t_regs;
    logic [31:0] e [7];
    e = '{32'h0, 32'(SRC_RST), 32'(LEVEL_RST), 32'(PRETRIG_RST),
      32'(HOLDOFF_RST), 32'(AUTO_TO_RST), 32'h0};
    for (int i = 0; i < 7; i++) begin
      rd_reg(4'(i), q);
      chk("reset value", e[i], q);
    end
    rd_reg(4'h9, q);
    chk("unmapped", 32'h0, q);
    wr_reg(OFS_STATUS, 32'hFF);
    rd_reg(OFS_STATUS, q);
    chk("status", 32'h0, q);
    wr_reg(OFS_PRETRIG, 32'h7F);
    rd_reg(OFS_PRETRIG, q);
    chk("clip", 32'(PCT_MAX), q);
    $display("register test done");
  endtask
  task automatic t_auto;
    int t0;
    val <= 8'h10;
    sel <= 4'h0;
    wr_reg(OFS_SRC, 32'h0);
    wr_reg(OFS_PRETRIG, 32'h32);
    wr_reg(OFS_AUTO_TO, 32'h20);
    wr_reg(OFS_CTRL, 32'h1);
    wait_st(3'h2);
    t0 = ntrig;
    for (int t = 1; t < 5; t++) begin
      wr_reg(OFS_CTRL, 32'h1 | 32'(t) << CTRL_TYPE_LSB);
      val <= 8'hF0;
      repeat (4) @(posedge clk);
      val <= 8'h10;
      repeat (4) @(posedge clk);
    end
    wr_reg(OFS_CTRL, 32'h1);
    repeat (64) @(posedge clk);
    chk("ntrig", 32'(t0), 32'(ntrig));
    wr_reg(OFS_CTRL, 32'h3);
    wait_trig(100, t0);
    rd_reg(OFS_STATUS, q);
    chk("forced", 32'h1, 32'(q[4]));
    drain(32, 8'h10, 8'h10, 1'b1);
    wr_reg(OFS_CTRL, 32'h1);
    wait_st(3'h2);
    chk("ntrig", 32'(t0 + 1), 32'(ntrig));
    wr_reg(OFS_CTRL, 32'h1 | 32'h1 << CTRL_FORCE_BIT);
    wait_trig(100, t0 + 1);
    rd_reg(OFS_STATUS, q);
    chk("soft force", 32'h1, 32'(q[4]));
    drain(32, 8'h10, 8'h10, 1'b1);
    wr_reg(OFS_CTRL, 32'h0);
    $display("auto test done");
  endtask
  task automatic t_edge(logic [4:0] src, logic f, int pct,
      logic [7:0] a, b, ea, eb, logic full);
    int t0;
    val <= a;
    sel <= src[3:0];
    wr_reg(OFS_SRC, 32'(src));
    wr_reg(OFS_PRETRIG, 32'(pct));
    t0 = ntrig;
    wr_reg(OFS_CTRL, 32'h1 | 32'(f) << CTRL_FALL_BIT);
    wait_st(3'h2);
    val <= b;
    wait_trig(200, t0);
    chk("busy", 32'h1, 32'(bsy));
    drain(pct * REC_LEN / 100, ea, eb, full);
    rd_reg(OFS_STATUS, q);
    chk("holdoff", 32'h5, 32'(q[2:0]));
    wr_reg(OFS_CTRL, 32'h0);
    chk("one trigger", 32'(t0 + 1), 32'(ntrig));
    $display("edge test source %0d done", src);
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_auto;
    t_edge(5'h00, 1'b0, 50, 8'h7F, 8'h80, 8'h7F, 8'h80, 1'b1);
    slow <= 1'b1;
    t_edge(5'h0F, 1'b1, 75, 8'h80, 8'h7F, 8'h80, 8'h7F, 1'b1);
    t_edge(SRC_AUX, 1'b0, 25, 8'h7F, 8'h80, 8'h00, 8'hFF, 1'b1);
    t_edge(SRC_LINE, 1'b0, 50, 8'h00, 8'h00, 8'h00, 8'hFF, 1'b0);
    give_verdict;
  end
endmodule // edge_trigger_capture_control_tb_top
